// ===== hw/bert_lock_consts.svh
// What this block does
// R01 - enabled: idle, one wait cycle, then acquire
// R02 - acquire compares received and local bytes, ten bytes
// R03 - clean window, no 24-zero run: lock
// R04 - 24-zero run during acquire returns to idle
// R05 - locked: count bit errors over 32 bytes
// R06 - 63-zero run while locked means lock lost
// R07 - window done without false lock: evaluate errors
// R08 - more than 32 errors: lock lost
// R09 - lost: set flag, bump count, back idle
// R10 - state advances only on word-rate enable cycles
// R11 - illegal state encoding sets sticky error flag
// R12 - lock-lost flag sticky until cleared
// R13 - eight-bit lock loss count output
// R14 - datapath gives error bits as two nibbles
// R15 - datapath gives sixteen-bit zero run count
// R16 - byte errors: ones in both nibbles added
// R17 - zero run counts zeros, restarts on one
// R18 - flag clear resets both sticky flags
// R19 - 32 or fewer errors: new window, stay locked
// R20 - locked asserted in monitor and evaluate states
`ifndef BERT_LOCK_CONSTS_SVH
`define BERT_LOCK_CONSTS_SVH

`define BERT_ACQ_BYTES 10
`define BERT_MON_BYTES 32
`define BERT_ACQ_ZERO_LIMIT 16'h0018
`define BERT_FALSE_LOCK_ZEROS 16'h003f
`define BERT_MAX_WIN_ERRORS 9'h020

`define BERT_BYTE_W 8
`define BERT_NIBBLE_W 4
`define BERT_NIB_SUM_W 4
`define BERT_ZERO_CNT_W 16
`define BERT_LOSS_CNT_W 8
`define BERT_ERR_CNT_W 9
`define BERT_BYTE_CNT_W 6

`define BERT_ADDR_W 4
`define BERT_DATA_W 32
`define BERT_REG_CTRL 4'h0
`define BERT_REG_STATUS 4'h4
`define BERT_REG_LOSS 4'h8
`define BERT_REG_ERRS 4'hc

`define BERT_CTRL_ENABLE_BIT 0
`define BERT_CTRL_CLEAR_BIT 1
`define BERT_STAT_LOCKED_BIT 0
`define BERT_STAT_LOST_BIT 1
`define BERT_STAT_ILLEGAL_BIT 2
`define BERT_STAT_STATE_LSB 4

`endif

// ===== hw/bert_lock_pkg.sv
`default_nettype none

package bert_lock_pkg;

    typedef enum logic [2:0] {
        IDLE_S,
        WAIT_S,
        ACQUIRE_S,
        MONITOR_S,
        EVAL_S,
        LOST_S
    } lock_state_e;

endpackage

`default_nettype wire

// ===== hw/err_sum_if.sv
`timescale 1ns/1ps
`default_nettype none

interface err_sum_if #(
    parameter int NIB_W = 4,
    parameter int SUM_W = 4
);
    logic [NIB_W-1:0] upper;
    logic [NIB_W-1:0] lower;
    logic [SUM_W-1:0] sum;

    modport calc (input upper, input lower, output sum);
    modport user (output upper, output lower, input sum);
endinterface

`default_nettype wire

// ===== hw/bert_err_popcount.sv
`timescale 1ns/1ps
`default_nettype none

module bert_err_popcount #(
    parameter int NIB_W = 4,
    parameter int SUM_W = 4
) (
    err_sum_if.calc bus
);
    if ((1 << SUM_W) <= 2 * NIB_W) begin : bad_sum_width
        $error("popcount sum width too narrow");
    end

    // each set bit in either nibble is one mismatched bit
    always_comb begin
        logic [SUM_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < NIB_W; i++) begin
            acc = acc + SUM_W'(bus.upper[i]) + SUM_W'(bus.lower[i]); // [R16]
        end
        bus.sum = acc;
    end
endmodule

`default_nettype wire

// ===== hw/bert_lock_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "bert_lock_consts.svh"

module bert_lock_controller
    import bert_lock_pkg::*;
#(
    parameter int ACQ_BYTES = `BERT_ACQ_BYTES,
    parameter int MON_BYTES = `BERT_MON_BYTES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic wordRateEnable,
    input wire logic bertEnable,
    input wire logic [`BERT_BYTE_W-1:0] rxByte,
    input wire logic [`BERT_BYTE_W-1:0] localPatternByte,
    input wire logic [`BERT_NIBBLE_W-1:0] errBitsUpper,
    input wire logic [`BERT_NIBBLE_W-1:0] errBitsLower,
    input wire logic [`BERT_ZERO_CNT_W-1:0] zeroRunCount,
    input wire logic flagClear,
    output logic locked,
    output logic lockLostFlag,
    output logic [`BERT_LOSS_CNT_W-1:0] lockLossCount,
    output logic fsmIllegalFlag,
    input wire logic [`BERT_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`BERT_DATA_W-1:0] avs_writedata,
    output logic [`BERT_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest
);
    if (ACQ_BYTES < 1 || ACQ_BYTES > (1 << `BERT_BYTE_CNT_W)) begin : bad_acq_bytes
        $error("acquire window out of range");
    end
    if (MON_BYTES < 1 || MON_BYTES > (1 << `BERT_BYTE_CNT_W)
        || MON_BYTES * `BERT_BYTE_W >= (1 << `BERT_ERR_CNT_W)) begin : bad_mon_bytes
        $error("monitor window out of range");
    end

    localparam logic [`BERT_BYTE_CNT_W-1:0] ACQ_LAST = `BERT_BYTE_CNT_W'(ACQ_BYTES - 1);
    localparam logic [`BERT_BYTE_CNT_W-1:0] MON_LAST = `BERT_BYTE_CNT_W'(MON_BYTES - 1);

    lock_state_e stateQ;
    lock_state_e stateD;
    lock_state_e stateNext;
    logic illegalNow;
    logic [`BERT_BYTE_CNT_W-1:0] byteCnt_q;
    logic mismatchSeen_q;
    logic [`BERT_ERR_CNT_W-1:0] errCnt_q;
    logic [`BERT_ERR_CNT_W-1:0] lastWinErrs_q;
    logic locked_q;
    logic lockLost_q;
    logic illegal_q;
    logic [`BERT_LOSS_CNT_W-1:0] lossCnt_q;
    logic ctrlEnable_q;
    logic clearPulse_q;
    logic wait_q;
    logic [`BERT_DATA_W-1:0] rdata_q;
    logic [`BERT_DATA_W-1:0] rdMux;
    logic runEn;
    logic clearFlags;
    logic byteMismatch;
    logic acqZeroRun;
    logic falseLock;
    logic tooManyErrs;
    logic busWriteDone;

    err_sum_if #(.NIB_W(`BERT_NIBBLE_W), .SUM_W(`BERT_NIB_SUM_W)) errBus ();

    assign errBus.upper = errBitsUpper; // [R14]
    assign errBus.lower = errBitsLower; // [R14]

    bert_err_popcount #(.NIB_W(`BERT_NIBBLE_W), .SUM_W(`BERT_NIB_SUM_W)) errCount (
        .bus(errBus)
    );

    assign runEn = bertEnable | ctrlEnable_q;
    assign clearFlags = flagClear | clearPulse_q;
    assign byteMismatch = (rxByte != localPatternByte); // [R02]
    // the zero run is trusted as delivered: it climbs per zero bit and restarts on a one
    assign acqZeroRun = (zeroRunCount >= `BERT_ACQ_ZERO_LIMIT); // [R15] [R17]
    assign falseLock = (zeroRunCount >= `BERT_FALSE_LOCK_ZEROS); // [R06]
    assign tooManyErrs = (errCnt_q > `BERT_MAX_WIN_ERRORS); // [R08]
    assign busWriteDone = avs_write & ~wait_q;

    always_comb begin
        stateNext = stateQ;
        illegalNow = 1'b0;
        case (stateQ)
            IDLE_S: begin
                if (runEn) begin
                    stateNext = WAIT_S; // [R01]
                end
            end
            WAIT_S: begin
                stateNext = ACQUIRE_S; // [R01]
            end
            ACQUIRE_S: begin
                if (acqZeroRun) begin
                    stateNext = IDLE_S; // [R04]
                end else if (byteCnt_q == ACQ_LAST) begin
                    // a dirty window simply starts another acquire window
                    if (!mismatchSeen_q && !byteMismatch) begin
                        stateNext = MONITOR_S; // [R03]
                    end
                end
            end
            MONITOR_S: begin
                if (falseLock) begin
                    stateNext = LOST_S; // [R06]
                end else if (byteCnt_q == MON_LAST) begin
                    stateNext = EVAL_S; // [R07]
                end
            end
            EVAL_S: begin
                if (tooManyErrs) begin
                    stateNext = LOST_S; // [R08]
                end else begin
                    stateNext = MONITOR_S; // [R19]
                end
            end
            LOST_S: begin
                stateNext = IDLE_S; // [R09]
            end
            default: begin
                stateNext = IDLE_S;
                illegalNow = 1'b1; // [R11]
            end
        endcase
        // dropping enable abandons the search, but a pending loss is still counted
        if (!runEn && stateQ != LOST_S) begin
            stateNext = IDLE_S;
        end
        stateD = wordRateEnable ? stateNext : stateQ; // [R10]
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            stateQ <= IDLE_S;
        end else begin
            stateQ <= stateD; // [R10]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            byteCnt_q <= '0;
        end else if (wordRateEnable) begin // [R10]
            if ((stateQ == ACQUIRE_S || stateQ == MONITOR_S) && stateD == stateQ
                && !(stateQ == ACQUIRE_S && byteCnt_q == ACQ_LAST)) begin
                byteCnt_q <= byteCnt_q + 1'b1; // [R02] [R05]
            end else begin
                byteCnt_q <= '0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mismatchSeen_q <= 1'b0;
        end else if (wordRateEnable) begin
            if (stateQ == ACQUIRE_S && stateD == ACQUIRE_S && byteCnt_q != ACQ_LAST) begin
                mismatchSeen_q <= mismatchSeen_q | byteMismatch; // [R02]
            end else begin
                mismatchSeen_q <= 1'b0;
            end
        end
    end

    // the count is held through evaluation and cleared on leaving it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            errCnt_q <= '0;
        end else if (wordRateEnable) begin
            if (stateQ == MONITOR_S && (stateD == MONITOR_S || stateD == EVAL_S)) begin
                errCnt_q <= errCnt_q + `BERT_ERR_CNT_W'(errBus.sum); // [R05] [R16]
            end else begin
                errCnt_q <= '0; // [R19]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            lastWinErrs_q <= '0;
        end else if (wordRateEnable && stateQ == EVAL_S) begin
            lastWinErrs_q <= errCnt_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            locked_q <= 1'b0;
        end else begin
            locked_q <= (stateD == MONITOR_S) || (stateD == EVAL_S); // [R20]
        end
    end

    // set wins over clear so a loss in the clearing cycle is kept
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lockLost_q <= 1'b0;
        end else if (wordRateEnable && stateQ == LOST_S) begin
            lockLost_q <= 1'b1; // [R09] [R12]
        end else if (clearFlags) begin
            lockLost_q <= 1'b0; // [R18]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            lossCnt_q <= '0;
        end else if (wordRateEnable && stateQ == LOST_S) begin
            lossCnt_q <= lossCnt_q + 1'b1; // [R09] [R13]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            illegal_q <= 1'b0;
        end else if (illegalNow) begin
            illegal_q <= 1'b1; // [R11]
        end else if (clearFlags) begin
            illegal_q <= 1'b0; // [R18]
        end
    end

    assign locked = locked_q;
    assign lockLostFlag = lockLost_q;
    assign lockLossCount = lossCnt_q;
    assign fsmIllegalFlag = illegal_q;

    // register slave: one wait cycle on every access, then the answer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wait_q <= 1'b1;
        end else if ((avs_read | avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_comb begin
        rdMux = '0;
        case (avs_address)
            `BERT_REG_CTRL: begin
                rdMux[`BERT_CTRL_ENABLE_BIT] = ctrlEnable_q;
            end
            `BERT_REG_STATUS: begin
                rdMux[`BERT_STAT_LOCKED_BIT] = locked_q;
                rdMux[`BERT_STAT_LOST_BIT] = lockLost_q;
                rdMux[`BERT_STAT_ILLEGAL_BIT] = illegal_q;
                rdMux[`BERT_STAT_STATE_LSB +: $bits(lock_state_e)] = stateQ;
            end
            `BERT_REG_LOSS: begin
                rdMux[`BERT_LOSS_CNT_W-1:0] = lossCnt_q;
            end
            `BERT_REG_ERRS: begin
                rdMux[`BERT_ERR_CNT_W-1:0] = lastWinErrs_q;
            end
            default: begin
                rdMux = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_q <= '0;
        end else if (avs_read && wait_q) begin
            rdata_q <= rdMux;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrlEnable_q <= 1'b0;
        end else if (busWriteDone && avs_address == `BERT_REG_CTRL) begin
            ctrlEnable_q <= avs_writedata[`BERT_CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            clearPulse_q <= 1'b0;
        end else begin
            clearPulse_q <= busWriteDone && avs_address == `BERT_REG_CTRL
                && avs_writedata[`BERT_CTRL_CLEAR_BIT];
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    wait_one_cycle_a: assert property ( // [R01]
        stateQ == IDLE_S && wordRateEnable && runEn ##1 wordRateEnable && runEn
        |=> stateQ == ACQUIRE_S ##0 $past(stateQ) == WAIT_S)
        else $error("wait state did not lead to acquire");

    hold_without_enable_a: assert property ( // [R10]
        !wordRateEnable |=> $stable(stateQ) && $stable(byteCnt_q) && $stable(errCnt_q))
        else $error("state moved without word-rate enable");

    acquire_lock_a: assert property ( // [R03]
        stateQ == ACQUIRE_S && wordRateEnable && runEn && byteCnt_q == ACQ_LAST
        && !mismatchSeen_q && rxByte == localPatternByte && zeroRunCount < `BERT_ACQ_ZERO_LIMIT
        |=> stateQ == MONITOR_S && locked)
        else $error("clean acquire window did not lock");

    acquire_zero_abort_a: assert property ( // [R04]
        stateQ == ACQUIRE_S && wordRateEnable && zeroRunCount >= `BERT_ACQ_ZERO_LIMIT
        |=> stateQ == IDLE_S && !locked)
        else $error("zero run in acquire did not restart");

    false_lock_a: assert property ( // [R06]
        stateQ == MONITOR_S && wordRateEnable && runEn && zeroRunCount >= `BERT_FALSE_LOCK_ZEROS
        |=> stateQ == LOST_S ##1 (lockLostFlag || !$past(wordRateEnable)))
        else $error("false lock to zeroes missed");

    window_length_a: assert property ( // [R05] [R07]
        stateQ == MONITOR_S && $past(stateQ) != MONITOR_S && wordRateEnable
        |-> byteCnt_q == '0)
        else $error("monitor window did not start at zero");

    error_sum_a: assert property ( // [R16]
        stateQ == MONITOR_S && wordRateEnable && runEn && zeroRunCount < `BERT_FALSE_LOCK_ZEROS
        |=> errCnt_q == $past(errCnt_q) + `BERT_ERR_CNT_W'($countones($past(errBitsUpper)))
            + `BERT_ERR_CNT_W'($countones($past(errBitsLower))))
        else $error("window error count wrong");

    eval_loss_a: assert property ( // [R08]
        stateQ == EVAL_S && wordRateEnable && runEn && errCnt_q > `BERT_MAX_WIN_ERRORS
        |=> stateQ == LOST_S)
        else $error("excess errors did not drop lock");

    eval_continue_a: assert property ( // [R19]
        stateQ == EVAL_S && wordRateEnable && runEn && errCnt_q <= `BERT_MAX_WIN_ERRORS
        |=> stateQ == MONITOR_S && errCnt_q == '0 && locked)
        else $error("good window did not restart monitoring");

    loss_count_a: assert property ( // [R09] [R13]
        stateQ == LOST_S && wordRateEnable
        |=> lockLostFlag && lockLossCount == $past(lockLossCount) + 1'b1 && stateQ == IDLE_S)
        else $error("lock loss not recorded");

    lost_sticky_a: assert property ( // [R12]
        lockLostFlag && !clearFlags |=> lockLostFlag)
        else $error("lock-lost flag dropped without clear");

    flag_clear_a: assert property ( // [R18]
        clearFlags && !(wordRateEnable && stateQ == LOST_S) && !illegalNow
        |=> !lockLostFlag && !fsmIllegalFlag)
        else $error("flag clear did not clear flags");

    illegal_sticky_a: assert property ( // [R11]
        fsmIllegalFlag && !clearFlags |=> fsmIllegalFlag)
        else $error("state error flag dropped without clear");

    locked_output_a: assert property ( // [R20]
        locked == (stateQ == MONITOR_S || stateQ == EVAL_S))
        else $error("locked output disagrees with state");
endmodule

`default_nettype wire

// ===== bench/prbs_datapath_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "bert_lock_consts.svh"

module prbs_datapath_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic wordRateEnable,
    input wire logic zeroMode,
    input wire logic [7:0] errMask,
    output logic [`BERT_BYTE_W-1:0] rxByte,
    output logic [`BERT_BYTE_W-1:0] localPatternByte,
    output logic [`BERT_NIBBLE_W-1:0] errBitsUpper,
    output logic [`BERT_NIBBLE_W-1:0] errBitsLower,
    output logic [`BERT_ZERO_CNT_W-1:0] zeroRunCount
);
    logic [6:0] seqQ;
    logic [15:0] runQ;

    // msb first; saturates so a long false lock never wraps back under the limit
    function automatic logic [15:0] nextRun(input logic [15:0] run, input logic [7:0] b);
        logic [15:0] r;
        r = run;
        for (int i = 7; i >= 0; i--) begin
            if (b[i]) begin
                r = 16'h0000;
            end else if (r != 16'hffff) begin
                r = r + 16'h0001;
            end
        end
        return r;
    endfunction

    // top bit kept high so a clean pattern never holds a long zero run
    assign localPatternByte = zeroMode ? 8'h00 : {1'b1, seqQ};
    assign errBitsUpper = errMask[7:4];
    assign errBitsLower = errMask[3:0];
    assign rxByte = localPatternByte ^ errMask;
    assign zeroRunCount = nextRun(runQ, rxByte);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            seqQ <= 7'h00;
            runQ <= 16'h0000;
        end else if (wordRateEnable) begin
            seqQ <= seqQ + 7'h01;
            runQ <= zeroRunCount;
        end
    end
endmodule

`default_nettype wire

// ===== bench/bert_lock_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bert_lock_consts.svh"

module bert_lock_controller_tb;
    logic core_clk, srst, wordRateEnable, bertEnable, flagClear, zeroMode;
    logic [7:0] errMask;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic locked, lockLostFlag, fsmIllegalFlag;
    logic [7:0] lockLossCount, rxByte, localPatternByte;
    logic [3:0] errBitsUpper, errBitsLower;
    logic [15:0] zeroRunCount;
    int numErrors = 0;
    int testsRun = 0;

    bert_lock_controller bert_lock_controller_i (.core_clk(core_clk), .srst(srst),
        .wordRateEnable(wordRateEnable), .bertEnable(bertEnable), .rxByte(rxByte),
        .localPatternByte(localPatternByte), .errBitsUpper(errBitsUpper), .errBitsLower(errBitsLower),
        .zeroRunCount(zeroRunCount), .flagClear(flagClear), .locked(locked), .lockLostFlag(lockLostFlag),
        .lockLossCount(lockLossCount), .fsmIllegalFlag(fsmIllegalFlag), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    prbs_datapath_model prbs_datapath_model_i (.core_clk(core_clk), .srst(srst),
        .wordRateEnable(wordRateEnable), .zeroMode(zeroMode), .errMask(errMask), .rxByte(rxByte),
        .localPatternByte(localPatternByte), .errBitsUpper(errBitsUpper), .errBitsLower(errBitsLower),
        .zeroRunCount(zeroRunCount));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tallyAndFinish();
        if (numErrors == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic busAccess(input logic wr, input logic [3:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check("bus answer", n < 50, 1'b1);
    endtask

    // polls at edges; gives up after the limit and lets the compare report it
    task automatic waitLocked(input logic exp, input int limit, input string what);
        int n;
        n = 0;
        while (locked !== exp && n < limit) begin
            @(posedge core_clk);
            n++;
        end
        check(what, locked, exp);
    endtask

    task automatic tResetValues();
        repeat (2) @(posedge core_clk);
        #1;
        check("locked", locked, 1'b0);
        check("lost flag", lockLostFlag, 1'b0);
        check("loss count", lockLossCount, 8'h00);
        check("waitrequest", avs_waitrequest, 1'b1);
    endtask

    task automatic tAcquire();
        @(posedge core_clk);
        bertEnable <= 1'b1;
        repeat (11) @(posedge core_clk);
        #1;
        check("locked early", locked, 1'b0);
        @(posedge core_clk);
        #1;
        check("locked on time", locked, 1'b1);
    endtask

    task automatic tCleanWindows();
        @(posedge core_clk);
        errMask <= 8'h10;
        repeat (100) @(posedge core_clk);
        #1;
        check("locked at limit", locked, 1'b1);
        check("lost flag", lockLostFlag, 1'b0);
        busAccess(1'b0, `BERT_REG_ERRS, 32'h0);
        check("window errors", rd, 32'h20);
    endtask

    task automatic tErrorLoss();
        @(posedge core_clk);
        errMask <= 8'h11;
        waitLocked(1'b0, 80, "unlock on errors");
        repeat (3) @(posedge core_clk);
        #1;
        check("lost flag", lockLostFlag, 1'b1);
        check("loss count", lockLossCount, 8'h01);
        busAccess(1'b0, `BERT_REG_ERRS, 32'h0);
        check("errors above limit", rd > 32'h20, 1'b1);
        errMask <= 8'h00;
        waitLocked(1'b1, 60, "relock");
        check("lost flag sticky", lockLostFlag, 1'b1);
        @(posedge core_clk);
        flagClear <= 1'b1;
        @(posedge core_clk);
        flagClear <= 1'b0;
        @(posedge core_clk);
        #1;
        check("lost flag cleared", lockLostFlag, 1'b0);
    endtask

    task automatic tFalseZero();
        logic seenHigh;
        seenHigh = 1'b0;
        @(posedge core_clk);
        wordRateEnable <= 1'b0;
        zeroMode <= 1'b1;
        repeat (50) @(posedge core_clk);
        #1;
        check("locked held", locked, 1'b1);
        check("count held", lockLossCount, 8'h01);
        @(posedge core_clk);
        wordRateEnable <= 1'b1;
        waitLocked(1'b0, 20, "false lock lost");
        repeat (3) @(posedge core_clk);
        #1;
        check("loss count", lockLossCount, 8'h02);
        repeat (100) begin
            @(posedge core_clk);
            #1;
            seenHigh = seenHigh | locked;
        end
        check("no lock on zeros", seenHigh, 1'b0);
        @(posedge core_clk);
        zeroMode <= 1'b0;
        busAccess(1'b1, `BERT_REG_CTRL, 32'h2);
        busAccess(1'b0, `BERT_REG_STATUS, 32'h0);
        check("status lost bit", rd[`BERT_STAT_LOST_BIT], 1'b0);
    endtask

    task automatic tRegisterRun();
        waitLocked(1'b1, 40, "relock after zeros");
        @(posedge core_clk);
        bertEnable <= 1'b0;
        waitLocked(1'b0, 40, "stop drops lock");
        busAccess(1'b1, `BERT_REG_CTRL, 32'h1);
        waitLocked(1'b1, 40, "register run locks");
        busAccess(1'b0, `BERT_REG_STATUS, 32'h0);
        check("status flags", rd[2:0], 3'b001);
        busAccess(1'b0, `BERT_REG_LOSS, 32'h0);
        check("loss register", rd, 32'h2);
        busAccess(1'b1, 4'h2, 32'hffffffff);
        busAccess(1'b0, 4'h2, 32'h0);
        check("unmapped read", rd, 32'h0);
        busAccess(1'b0, `BERT_REG_CTRL, 32'h0);
        check("control", rd, 32'h1);
        busAccess(1'b1, `BERT_REG_CTRL, 32'h0);
        waitLocked(1'b0, 40, "register stop");
        check("illegal flag", fsmIllegalFlag, 1'b0);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        #80000;
        numErrors++;
        tallyAndFinish();
    end

    initial begin
        srst = 1'b1;
        wordRateEnable = 1'b1;
        bertEnable = 1'b0;
        flagClear = 1'b0;
        zeroMode = 1'b0;
        errMask = 8'h00;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        tResetValues();
        tAcquire();
        tCleanWindows();
        tErrorLoss();
        tFalseZero();
        tRegisterRun();
        tallyAndFinish();
    end
endmodule

`default_nettype wire
